// ---- core/fsp_fifo.sv ----
// Command queue with registered read data
`timescale 1ns/100ps
module fsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    fsp_stream_if.queue q
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] count;
        logic ready;
        logic [WIDTH-1:0] out_data;
        logic out_valid;
    } fsp_fifo_state_type;

    fsp_fifo_state_type s_reg;
    fsp_fifo_state_type s_next;
    logic push;
    logic take;
    logic load;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Output word is a register; refilled when empty or consumed
    always_comb
    begin
        s_next = s_reg;
        push = q.in_valid && s_reg.ready;
        take = s_reg.out_valid && q.out_ready;
        load = (s_reg.count != '0) && (!s_reg.out_valid || take);
        if (push)
        begin
            s_next.mem[s_reg.wptr] = q.in_data;
            s_next.wptr = s_reg.wptr + PW'(1);
        end
        if (load)
        begin
            s_next.out_data = s_reg.mem[s_reg.rptr];
            s_next.rptr = s_reg.rptr + PW'(1);
            s_next.out_valid = 1'h1;
        end
        else if (take)
        begin
            s_next.out_valid = 1'h0;
        end
        if (push && !load)
        begin
            s_next.count = s_reg.count + CW'(1);
        end
        else if (load && !push)
        begin
            s_next.count = s_reg.count - CW'(1);
        end
        // Registered full flag: ready never depends on the input
        s_next.ready = (s_next.count != CW'(DEPTH));
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.ready <= 1'h1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign q.in_ready = s_reg.ready;
    assign q.out_valid = s_reg.out_valid;
    assign q.out_data = s_reg.out_data;
endmodule // fsp_fifo

// ---- core/fsp_pkg.sv ----
// Constants and types shared by the frame store SDRAM port files
package fsp_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 48;
    localparam int NARROW_W = 32;
    localparam int MASK_W = 4;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int BOOT_SAMPLE_NS = 320;
    // Least time, so round up
    localparam int BOOT_SAMPLE_CYC =
        (BOOT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_CNT_W = 5;
    localparam int CAS_LAT = 2;
    localparam int SYNC_STAGES = 2;
    // Two system clocks per memory clock, plus sampling
    localparam int READ_LAT_CYC = 2 * CAS_LAT + SYNC_STAGES + 2;

    // ----------------------------------------------------------------
    // Pin codes {row, col, write}, reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] PIN_NOP = 3'h7;
    localparam logic [2:0] PIN_ACT = 3'h3;
    localparam logic [2:0] PIN_READ = 3'h5;
    localparam logic [2:0] PIN_WRITE = 3'h4;
    localparam logic [2:0] PIN_PRE = 3'h2;
    localparam logic [2:0] PIN_REF = 3'h1;
    localparam logic [2:0] PIN_MODE = 3'h0;
    localparam logic [2:0] PIN_BST = 3'h6;
    localparam logic [MASK_W-1:0] MASK_ALL = 4'hF;
    localparam logic RST_WIDE = 1'h0;
    localparam logic [DATA_W-1:0] OE_WIDE = 48'hFFFF_FFFF_FFFF;
    localparam logic [DATA_W-1:0] OE_NARROW = 48'h0000_FFFF_FFFF;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_ACT = 3'h1,
        OP_READ = 3'h2,
        OP_WRITE = 3'h3,
        OP_PRE = 3'h4,
        OP_REF = 3'h5,
        OP_MODE = 3'h6,
        OP_BST = 3'h7
    } fsp_op_type;

    typedef enum logic [1:0] {
        ST_BOOT = 2'h1,
        ST_RUN = 2'h2
    } fsp_state_type;

    typedef struct packed {
        fsp_op_type op;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] mask;
        logic [DATA_W-1:0] data;
    } fsp_cmd_type;

    localparam int CMD_W = $bits(fsp_cmd_type);
endpackage

// ---- core/fsp_sdram_port.sv ----
// Frame store SDRAM pin port: command issue, straps, data bus
//
// Contract
// - A memory clock goes out and all pins change away from its rise.
// - Memory clock enable is driven and high means enabled.
// - The row strobe is driven active low.
// - The column strobe is driven active low.
// - The write enable is driven active low.
// - Four byte mask outputs give byte granular overlay access.
// - Mask bits 0..3 cover data bytes 7:0, 15:8, 23:16, 31:24.
// - The mask outputs are active high.
// - Row and column addresses share one 14-bit address bus.
// - All 14 address lines are sampled as straps, so they are two-way.
// - The data bus is two-way and runs 48 or 32 bits wide.
// - After reset the data bus is 32 bits wide until changed.
// - The memory clock runs even with no memory fitted.
`timescale 1ns/100ps
module fsp_sdram_port (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire fsp_pkg::fsp_op_type cmd_op,
    input wire logic [13:0] cmd_addr,
    input wire logic [3:0] cmd_mask,
    input wire logic [47:0] cmd_wdata,
    output logic rd_valid,
    output logic [47:0] rd_data,
    input wire logic width_wr,
    input wire logic width_sel,
    output logic width_wide,
    output logic boot_done,
    output logic [13:0] boot_cfg,
    output logic mem_clk_out,
    output logic mem_clk_en,
    output logic mem_row_strobe_n,
    output logic mem_col_strobe_n,
    output logic mem_write_en_n,
    output logic [3:0] mem_byte_mask,
    input wire logic [13:0] mem_addr_bus_in,
    output logic [13:0] mem_addr_bus_out,
    output logic [13:0] mem_addr_bus_oe,
    input wire logic [47:0] mem_data_bus_in,
    output logic [47:0] mem_data_bus_out,
    output logic [47:0] mem_data_bus_oe
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        fsp_pkg::fsp_state_type st;
        logic clk_out;
        logic cke;
        logic [2:0] pins;
        logic [3:0] mask;
        logic [13:0] addr_out;
        logic [13:0] addr_oe;
        logic [47:0] data_out;
        logic [47:0] data_oe;
        logic [13:0] addr_s1;
        logic [13:0] addr_s2;
        logic [47:0] data_s1;
        logic [47:0] data_s2;
        logic [13:0] boot_cfg;
        logic [fsp_pkg::BOOT_CNT_W-1:0] boot_cnt;
        logic boot_done;
        logic wide;
        logic [fsp_pkg::READ_LAT_CYC-1:0] rd_pipe;
        logic rd_valid;
        logic [47:0] rd_data;
    } fsp_port_state_type;

    fsp_port_state_type s_reg;
    fsp_port_state_type s_next;
    fsp_pkg::fsp_cmd_type head;
    fsp_pkg::fsp_cmd_type cmd_word;
    logic drain;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Strobe pattern {row, col, write}, all active low
    function automatic logic [2:0] op_pins(fsp_pkg::fsp_op_type op);
        logic [2:0] p;
        p = fsp_pkg::PIN_NOP;
        unique case (op)
            fsp_pkg::OP_NOP: p = fsp_pkg::PIN_NOP;
            fsp_pkg::OP_ACT: p = fsp_pkg::PIN_ACT;
            fsp_pkg::OP_READ: p = fsp_pkg::PIN_READ;
            fsp_pkg::OP_WRITE: p = fsp_pkg::PIN_WRITE;
            fsp_pkg::OP_PRE: p = fsp_pkg::PIN_PRE;
            fsp_pkg::OP_REF: p = fsp_pkg::PIN_REF;
            fsp_pkg::OP_MODE: p = fsp_pkg::PIN_MODE;
            fsp_pkg::OP_BST: p = fsp_pkg::PIN_BST;
        endcase
        return p;
    endfunction

    // Data lanes in use for the selected bus width
    function automatic logic [47:0] lane_oe(logic wide);
        return wide ? fsp_pkg::OE_WIDE : fsp_pkg::OE_NARROW;
    endfunction

    // ----------------------------------------------------------------
    // Command queue
    // ----------------------------------------------------------------
    fsp_stream_if #(.WIDTH(fsp_pkg::CMD_W)) cmd_q ();

    // Caller's command packed into one queue word
    always_comb
    begin
        cmd_word.op = cmd_op;
        cmd_word.addr = cmd_addr;
        cmd_word.mask = cmd_mask;
        cmd_word.data = cmd_wdata;
    end

    assign cmd_q.in_valid = cmd_valid;
    assign cmd_q.in_data = cmd_word;
    assign cmd_q.out_ready = drain;
    assign head = fsp_pkg::fsp_cmd_type'(cmd_q.out_data);

    fsp_fifo #(
        .WIDTH(fsp_pkg::CMD_W),
        .DEPTH(fsp_pkg::FIFO_DEPTH)
    ) u_cmd_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .q(cmd_q.queue)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Pins move only when the memory clock falls, half a period of
    // setup before its rise; queue drains at most every other cycle
    always_comb
    begin
        s_next = s_reg;
        drain = 1'h0;
        // Free running, also with no memory fitted
        s_next.clk_out = !s_reg.clk_out;
        // Pin inputs pass two flops before use
        s_next.addr_s1 = mem_addr_bus_in;
        s_next.addr_s2 = s_reg.addr_s1;
        s_next.data_s1 = mem_data_bus_in;
        s_next.data_s2 = s_reg.data_s1;
        // Read return pipe, tuned to latency and sampling
        s_next.rd_pipe = {s_reg.rd_pipe[fsp_pkg::READ_LAT_CYC-2:0], 1'h0};
        s_next.rd_valid = s_reg.rd_pipe[fsp_pkg::READ_LAT_CYC-1];
        if (s_reg.rd_pipe[fsp_pkg::READ_LAT_CYC-1])
        begin
            s_next.rd_data = s_reg.data_s2 & lane_oe(s_reg.wide);
        end
        // Width stays narrow until written
        if (width_wr)
        begin
            s_next.wide = width_sel;
        end
        unique case (s_reg.st)
            fsp_pkg::ST_BOOT:
            begin
                // Address bus released so straps can be read
                if (s_reg.boot_cnt ==
                    fsp_pkg::BOOT_CNT_W'(fsp_pkg::BOOT_SAMPLE_CYC - 1))
                begin
                    s_next.boot_cfg = s_reg.addr_s2;
                    s_next.boot_done = 1'h1;
                    s_next.addr_oe = 14'h3FFF;
                    s_next.cke = 1'h1;
                    s_next.st = fsp_pkg::ST_RUN;
                end
                else
                begin
                    s_next.boot_cnt = s_reg.boot_cnt +
                        fsp_pkg::BOOT_CNT_W'(1);
                end
            end
            fsp_pkg::ST_RUN:
            begin
                if (s_reg.clk_out)
                begin
                    // Idle slot: no operation, all lanes open
                    s_next.pins = fsp_pkg::PIN_NOP;
                    s_next.mask = fsp_pkg::MASK_ALL;
                    s_next.data_oe = '0;
                    if (cmd_q.out_valid)
                    begin
                        drain = 1'h1;
                        // Low strobes mark the command
                        s_next.pins = op_pins(head.op);
                        // Row or column on the same lines
                        s_next.addr_out = head.addr;
                        if (head.op == fsp_pkg::OP_READ ||
                            head.op == fsp_pkg::OP_WRITE)
                        begin
                            // Bit n enables byte n of 31:0
                            s_next.mask = head.mask;
                        end
                        if (head.op == fsp_pkg::OP_READ)
                        begin
                            s_next.rd_pipe[0] = 1'h1;
                        end
                        if (head.op == fsp_pkg::OP_WRITE)
                        begin
                            s_next.data_out = head.data;
                            s_next.data_oe = lane_oe(s_reg.wide);
                        end
                    end
                end
            end
            default:
            begin
                s_next.st = fsp_pkg::ST_BOOT;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Strobes idle high and width narrow out of reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.st <= fsp_pkg::ST_BOOT;
            s_reg.pins <= fsp_pkg::PIN_NOP;
            s_reg.mask <= fsp_pkg::MASK_ALL;
            s_reg.wide <= fsp_pkg::RST_WIDE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign cmd_ready = cmd_q.in_ready;
    assign rd_valid = s_reg.rd_valid;
    assign rd_data = s_reg.rd_data;
    assign width_wide = s_reg.wide;
    assign boot_done = s_reg.boot_done;
    assign boot_cfg = s_reg.boot_cfg;
    assign mem_clk_out = s_reg.clk_out;
    assign mem_clk_en = s_reg.cke;
    assign mem_row_strobe_n = s_reg.pins[2];
    assign mem_col_strobe_n = s_reg.pins[1];
    assign mem_write_en_n = s_reg.pins[0];
    assign mem_byte_mask = s_reg.mask;
    assign mem_addr_bus_out = s_reg.addr_out;
    assign mem_addr_bus_oe = s_reg.addr_oe;
    assign mem_data_bus_out = s_reg.data_out;
    assign mem_data_bus_oe = s_reg.data_oe;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence rd_issue_s;
        !mem_clk_out && {mem_row_strobe_n, mem_col_strobe_n,
            mem_write_en_n} == fsp_pkg::PIN_READ;
    endsequence

    sequence rd_return_s;
        ##8 rd_valid;
    endsequence

    property rd_lat_p;
        rd_issue_s |-> rd_return_s;
    endproperty

    clock_runs_a: assert property (
        $past(rst_n) |-> mem_clk_out != $past(mem_clk_out))
        else $error("memory clock stopped");

    pins_at_fall_a: assert property (
        !mem_clk_out |=> $stable({mem_row_strobe_n, mem_col_strobe_n,
            mem_write_en_n, mem_byte_mask, mem_data_bus_oe}))
        else $error("memory pins moved near clock rise");

    cke_after_boot_a: assert property (
        mem_clk_en == boot_done)
        else $error("clock enable not tied to boot end");

    cmd_needs_cke_a: assert property (
        (!mem_row_strobe_n || !mem_col_strobe_n) |-> mem_clk_en)
        else $error("command issued with clock disabled");

    read_latency_a: assert property (rd_lat_p)
        else $error("read data not returned on time");

    read_cause_a: assert property (
        rd_valid |-> $past(mem_row_strobe_n, 8) &&
            !$past(mem_col_strobe_n, 8) && $past(mem_write_en_n, 8))
        else $error("read data without a read");

    write_drive_a: assert property (
        (mem_data_bus_oe != '0) |-> !mem_write_en_n && !mem_col_strobe_n
            && mem_data_bus_oe == lane_oe(width_wide))
        else $error("data driven outside a write");

    narrow_default_a: assert property (
        width_wide |-> $past(width_wr && width_sel) ||
            ($past(width_wide) && !$past(width_wr)))
        else $error("wide bus without being selected");

    mask_idle_a: assert property (
        mem_row_strobe_n && mem_col_strobe_n |-> mem_byte_mask == 4'hF)
        else $error("lane disabled outside an access");

    strap_capture_a: assert property (
        $rose(boot_done) |-> boot_cfg == $past(s_reg.addr_s2)
            && $past(mem_addr_bus_oe) == 14'h0000)
        else $error("straps not taken with bus released");

    addr_driven_a: assert property (
        boot_done |-> mem_addr_bus_oe == 14'h3FFF)
        else $error("address bus not driven after boot");
endmodule // fsp_sdram_port

// ---- core/fsp_stream_if.sv ----
// Valid/ready stream carrier between the port and its command queue
`timescale 1ns/100ps
interface fsp_stream_if #(parameter int WIDTH = 8) ();
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport queue (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data);
endinterface // fsp_stream_if

// ---- sim/fsp_sdram_model.sv ----
// Behavioural SDRAM standing on the frame store pins
`timescale 1ns/100ps
module fsp_sdram_model (
    input wire logic mem_clk_out,
    input wire logic mem_clk_en,
    input wire logic mem_row_strobe_n,
    input wire logic mem_col_strobe_n,
    input wire logic mem_write_en_n,
    input wire logic [3:0] mem_byte_mask,
    input wire logic [13:0] addr_wire,
    input wire logic [47:0] data_wire,
    output logic [47:0] dq_out,
    output logic [47:0] dq_oe
);
    logic [47:0] mem [0:15];
    logic [47:0] rd_word;
    logic [3:0] rd_mask;
    int pend;

    // ----------------------------------------------------------------
    // Start-up
    // ----------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 16; i++) mem[i] = 48'h0;
        dq_out = 48'h0;
        dq_oe = 48'h0;
        pend = 0;
    end

    // Commands latched on the memory clock rise, only while enabled
    always @(posedge mem_clk_out)
    begin
        // Read burst of one: drive from one clock after the command
        // until the clock rise after the CAS latency edge, then let go
        if (pend > 0) pend--;
        if (pend == 2)
        begin
            dq_out = rd_word;
            for (int b = 0; b < 4; b++)
                dq_oe[b*8 +: 8] = {8{rd_mask[b]}};
            dq_oe[47:32] = 16'hFFFF;
        end
        if (pend == 0) dq_oe = 48'h0; // Released: pull-down shows
        if (mem_clk_en === 1'b1)
        begin
            case ({mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n})
                3'h4: // Write
                begin
                    for (int b = 0; b < 4; b++)
                        if (mem_byte_mask[b])
                            mem[addr_wire[3:0]][b*8 +: 8] = data_wire[b*8 +: 8];
                    mem[addr_wire[3:0]][47:32] = data_wire[47:32];
                end
                3'h5: // Read
                begin
                    rd_word = mem[addr_wire[3:0]];
                    rd_mask = mem_byte_mask;
                    pend = 3;
                end
                default: ;
            endcase
        end
    end
endmodule // fsp_sdram_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the frame store SDRAM port
`timescale 1ns/100ps
module tb_top;
    logic mclk, rst_n, cmd_valid, width_wr, width_sel;
    fsp_pkg::fsp_op_type cmd_op;
    logic [13:0] cmd_addr, aout, aoe, addr_w, strap, boot_cfg, last_addr;
    logic [3:0] cmd_mask, bmask, last_mask;
    logic [47:0] cmd_wdata, rd_data, dout, doe, mout, moe, data_w, last_oe;
    logic cmd_ready, rd_valid, width_wide, boot_done;
    logic clk_o, cke, ras_n, cas_n, we_n, prev, refused;
    logic [2:0] last_code;
    logic [47:0] shadow [0:15];
    int fail_count, check_count, seed, n_pins, acc;

    // ----------------------------------------------------------------
    // Clock, wires, instances
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Straps are board resistors; data lines have pull-downs
    assign addr_w = (aoe & aout) | (~aoe & strap);
    assign data_w = (doe & dout) | (~doe & moe & mout);

    fsp_sdram_port u_fsp_sdram_port (.mclk(mclk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_mask(cmd_mask), .cmd_wdata(cmd_wdata),
        .rd_valid(rd_valid), .rd_data(rd_data), .width_wr(width_wr),
        .width_sel(width_sel), .width_wide(width_wide),
        .boot_done(boot_done), .boot_cfg(boot_cfg), .mem_clk_out(clk_o),
        .mem_clk_en(cke), .mem_row_strobe_n(ras_n),
        .mem_col_strobe_n(cas_n), .mem_write_en_n(we_n),
        .mem_byte_mask(bmask), .mem_addr_bus_in(addr_w),
        .mem_addr_bus_out(aout), .mem_addr_bus_oe(aoe),
        .mem_data_bus_in(data_w), .mem_data_bus_out(dout),
        .mem_data_bus_oe(doe));

    fsp_sdram_model u_fsp_sdram_model (.mem_clk_out(clk_o),
        .mem_clk_en(cke), .mem_row_strobe_n(ras_n),
        .mem_col_strobe_n(cas_n), .mem_write_en_n(we_n),
        .mem_byte_mask(bmask), .addr_wire(addr_w), .data_wire(data_w),
        .dq_out(mout), .dq_oe(moe));

    // Pin monitor: what the memory sees at each clock rise
    always @(posedge clk_o)
    begin
        if (cke === 1'b1 && {ras_n, cas_n, we_n} !== 3'h7)
        begin
            last_code <= {ras_n, cas_n, we_n};
            last_addr <= addr_w;
            last_mask <= bmask;
            last_oe <= doe;
            n_pins <= n_pins + 1;
        end
    end

    // ----------------------------------------------------------------
    // Tasks and functions
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [47:0] e,
                         input logic [47:0] s);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic [2:0] code_of(input fsp_pkg::fsp_op_type op);
        case (op)
            fsp_pkg::OP_ACT: return 3'h3;
            fsp_pkg::OP_READ: return 3'h5;
            fsp_pkg::OP_WRITE: return 3'h4;
            fsp_pkg::OP_PRE: return 3'h2;
            fsp_pkg::OP_REF: return 3'h1;
            fsp_pkg::OP_MODE: return 3'h0;
            fsp_pkg::OP_BST: return 3'h6;
            default: return 3'h7;
        endcase
    endfunction

    // Narrow mode leaves the top lines to the pull-down
    function automatic logic [47:0] merge(input logic [47:0] old,
        input logic [47:0] d, input logic [3:0] m, input logic w);
        logic [47:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (m[b]) r[b*8 +: 8] = d[b*8 +: 8];
        r[47:32] = w ? d[47:32] : 16'h0;
        return r;
    endfunction

    // Request held from a falling edge until the rise that takes it
    task automatic push(input fsp_pkg::fsp_op_type op, input logic [13:0] a,
                        input logic [3:0] m, input logic [47:0] d);
        int k;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_mask = m;
        cmd_wdata = d;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 50)
        begin
            @(negedge mclk);
            k++;
        end
        @(posedge mclk);
    endtask

    task automatic issue(input fsp_pkg::fsp_op_type op, input logic [13:0] a,
                         input logic [3:0] m, input logic [47:0] d);
        int n0;
        int k;
        n0 = n_pins;
        push(op, a, m, d);
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (k = 0; k < 20 && n_pins == n0; k++) @(negedge mclk);
        check("pin code", code_of(op), last_code);
        check("pin addr", a, last_addr);
    endtask

    task automatic wr(input logic [3:0] a, input logic [3:0] m,
                      input logic [47:0] d);
        issue(fsp_pkg::OP_WRITE, {10'h0, a}, m, d);
        check("write mask", m, last_mask);
        check("write oe", width_wide ? 48'hFFFF_FFFF_FFFF
              : 48'h0000_FFFF_FFFF, last_oe);
        shadow[a] = merge(shadow[a], d, m, width_wide);
    endtask

    task automatic rd(input logic [3:0] a);
        int k;
        issue(fsp_pkg::OP_READ, {10'h0, a}, 4'hF, 48'h0);
        for (k = 0; k < 30 && rd_valid !== 1'b1; k++) @(negedge mclk);
        check("read valid", 48'h1, {47'h0, rd_valid});
        check("read data", width_wide ? shadow[a]
              : {16'h0, shadow[a][31:0]}, rd_data);
    endtask

    task automatic setw(input logic s);
        @(negedge mclk);
        width_wr = 1'b1;
        width_sel = s;
        @(negedge mclk);
        width_wr = 1'b0;
        check("width", {47'h0, s}, {47'h0, width_wide});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 58446;
        {fail_count, check_count, n_pins, acc} = '0;
        {cmd_valid, width_wr, width_sel, refused} = '0;
        cmd_op = fsp_pkg::OP_NOP;
        {cmd_addr, cmd_mask, cmd_wdata} = '0;
        for (int i = 0; i < 16; i++) shadow[i] = 48'h0;
        strap = 14'($random(seed));
        rst_n = 1'b0;
        repeat (10) @(negedge mclk);
        check("cke in reset", 48'h0, {47'h0, cke});
        check("strobes idle", 48'h7, {45'h0, ras_n, cas_n, we_n});
        check("width reset", 48'h0, {47'h0, width_wide});
        check("addr oe reset", 48'h0, {34'h0, aoe});
        rst_n = 1'b1;
        @(negedge mclk);
        check("boot early", 48'h0, {47'h0, boot_done});
        // Memory clock must run with no traffic at all
        prev = clk_o;
        repeat (6)
        begin
            @(negedge mclk);
            check("clk toggle", {47'h0, ~prev}, {47'h0, clk_o});
            prev = clk_o;
        end
        for (int k = 0; k < 40 && boot_done !== 1'b1; k++) @(negedge mclk);
        check("straps", {34'h0, strap}, {34'h0, boot_cfg});
        check("cke run", 48'h1, {47'h0, cke});
        check("addr oe run", 48'h3FFF, {34'h0, aoe});
        // Every command code except NOP once
        for (int i = 1; i < 8; i++)
        begin
            issue(fsp_pkg::fsp_op_type'(i), 14'($random(seed)), 4'hF,
                  48'h0);
            repeat (10) @(negedge mclk);
        end
        // Narrow writes, corner masks first, then random
        wr(4'h0, 4'h0, 48'hFFFF_FFFF_FFFF);
        wr(4'h1, 4'hF, {$random(seed), $random(seed)});
        for (int j = 2; j < 6; j++)
            wr(4'(j), 4'($random(seed)), {$random(seed), $random(seed)});
        for (int j = 0; j < 6; j++) rd(4'(j));
        // Wide mode, then back to narrow on the same word
        setw(1'b1);
        for (int j = 8; j < 11; j++)
            wr(4'(j), 4'($random(seed)), {$random(seed), $random(seed)});
        for (int j = 8; j < 11; j++) rd(4'(j));
        setw(1'b0);
        rd(4'h8);
        // Back to back for 30 cycles, on past the queue's first refusal
        @(negedge mclk);
        acc = -n_pins;
        cmd_valid = 1'b1;
        cmd_op = fsp_pkg::OP_ACT;
        // Ready seen before each rise is what that rise takes
        for (int k = 0; k < 30; k++)
        begin
            if (cmd_ready === 1'b1) acc = acc - 1;
            else refused = 1'b1;
            @(negedge mclk);
        end
        cmd_valid = 1'b0;
        repeat (60) @(negedge mclk);
        check("refused", 48'h1, {47'h0, refused});
        check("issued", 48'h0, 48'(n_pins + acc));
        results();
    end

    // Guard against a hang
    initial
    begin
        #200000;
        fail_count++;
        results();
    end
endmodule // tb_top
